// file: logic/tgd_cfg.svh
// Codes, widths and timing counts of the trigger and coarse-delay block.
`ifndef TGD_CFG_SVH
`define TGD_CFG_SVH

// System clock period in picoseconds (40 MHz).
`define TGD_CLK_PS 25000
// Nominal timebase period in picoseconds; unused, the coarse delay steps on the system clock.
`define TGD_TIMEBASE_PS 25600

// Stretcher hold time after the last edge, a least time rounded up.
`define TGD_STRETCH_NS 200
`define TGD_STRETCH_CYC ((`TGD_STRETCH_NS * 1000 + `TGD_CLK_PS - 1) / `TGD_CLK_PS)

// Hold sampling window, a least time rounded up.
`define TGD_HOLD_NS 3300
`define TGD_HOLD_CYC ((`TGD_HOLD_NS * 1000 + `TGD_CLK_PS - 1) / `TGD_CLK_PS)

// Trigger source select codes.
`define TGD_SEL_CHA 2'h0
`define TGD_SEL_CHB 2'h1
`define TGD_SEL_SOFT 2'h2
`define TGD_SEL_EXT 2'h3

// Counter stage widths: fast first stage, second stage, upper stages.
`define TGD_W_FIRST 4
`define TGD_W_SECOND 4
`define TGD_W_UPPER 16

`endif

// file: logic/tgd_pkg.sv
// Types shared by the trigger and coarse-delay block.
package tgd_pkg;

  // Sequence of one delayed sample.
  typedef enum logic [2:0] {
    TGD_ST_IDLE,
    TGD_ST_ARMED,
    TGD_ST_RAMP1,
    TGD_ST_COUNT,
    TGD_ST_RAMP2
  } tgd_state_t;

endpackage

// file: logic/tgd_stage_if.sv
// Signals between the delay controller and one counter stage.
`timescale 1ns/1ps
interface tgd_stage_if #(
  parameter int W = 4
);
  logic load;
  logic tick;
  logic [W-1:0] d;
  logic [W-1:0] q;
  logic full;

  modport stage (input load, input tick, input d, output q, output full);
  modport ctrl (output load, output tick, output d, input q, input full);
endinterface

// file: logic/tgd_stage.sv
// One loadable binary up-counter stage of the coarse delay chain.
`timescale 1ns/1ps
module tgd_stage (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  tgd_stage_if.stage s
);
  // Loads on a tick while load is held, otherwise counts up on a tick.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s.q <= '0;
    end else if (s.tick && s.load) begin
      s.q <= s.d;
    end else if (s.tick) begin
      s.q <= s.q + 1'b1;
    end
  end

  // Terminal count of the stage.
  assign s.full = &s.q;
endmodule // tgd_stage

// file: logic/tgd_delay_top.sv
// Trigger selection, stretcher, reset latch and coarse delay counter.
// How it works
// - Mux routes one of channel A, channel B, software or external trigger.
// - Trigger inputs are active low, the software strobe active high; only the selected one is looked at.
// - Only the first leading edge of a stretched pulse starts a sequence.
// - Stretch holds until 200 ns after the last edge, restarted per edge.
// - One-shot fires only on a falling input; arming sets on high input.
// - System clock period of 25 ns is the coarse delay unit.
// - Counter ticks while count enable or the load strobe is active.
// - Coarse delay in steps of one system clock, up to about 419 ms.
// - Counter output is a registered one-cycle pulse after the chain is full.
// - Fast stage full feeds second, its carry feeds upper stages.
// - Load happens on one tick while the load strobe is held.
// - After the reset latch sets, exactly the next trigger is accepted.
// - Latch set clears ramp control, presets ramp, clears hold, signals ready.
// - Latch sets from end-of-sample or the processor reset strobe.
// - The sample acknowledge strobe clears the voltage hold.
// - Hold trigger opens a 3.3 us window; its start releases the clamp.
// - First edge after trigger enables the gate; next edge counts.
`timescale 1ns/1ps
`include "tgd_cfg.svh"
module tgd_delay_top
  import tgd_pkg::*;
#(
  parameter int W_FIRST = `TGD_W_FIRST,
  parameter int W_SECOND = `TGD_W_SECOND,
  parameter int W_UPPER = `TGD_W_UPPER,
  parameter int W_LEVEL = 10
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic trig_a_n_i,
  input wire logic trig_b_n_i,
  input wire logic ext_trig_n_i,
  input wire logic soft_trig_i,
  input wire logic [1:0] trig_sel_i,
  input wire logic [W_LEVEL-1:0] trig_level_i,
  input wire logic [W_FIRST+W_SECOND+W_UPPER-1:0] delay_word_i,
  input wire logic load_i,
  input wire logic reset_cmd_i,
  input wire logic new_data_ack_i,
  input wire logic sample_done_i,
  output logic [W_LEVEL-1:0] trig_level_o,
  output logic stretch_o,
  output logic ready_o,
  output logic ramp_preset_o,
  output logic comp_latch_o,
  output logic ramp_on_o,
  output logic gate_en_o,
  output logic count_out_o,
  output logic hold_sample_o,
  output logic hold_clear_o,
  output logic clamp_release_o
);
  localparam int W_ALL = W_FIRST + W_SECOND + W_UPPER;
  localparam logic [7:0] STRETCH_CYC = 8'(`TGD_STRETCH_CYC);
  localparam logic [11:0] HOLD_CYC = 12'(`TGD_HOLD_CYC);

  logic a_s1_r;
  logic a_s2_r;
  logic b_s1_r;
  logic b_s2_r;
  logic e_s1_r;
  logic e_s2_r;
  logic done_s1_r;
  logic done_s2_r;
  logic done_prev_r;
  logic mux_n;
  logic mux_prev_r;
  logic arm_r;
  logic [7:0] stretch_cnt_r;
  logic stretch_r;
  logic stretch_prev_r;
  logic init_r;
  logic start;
  logic latch_r;
  logic latch_set;
  logic accept;
  tgd_state_t state_r;
  tgd_state_t state_nxt;
  logic count_en_r;
  logic gate;
  logic all_full;
  logic count_out_r;
  logic ramp_on_r;
  logic [11:0] hold_cnt_r;
  logic hold_sample_r;
  logic hold_clear_r;
  logic clamp_rel_r;
  logic [W_LEVEL-1:0] level_r;
  logic done_evt;

  tgd_stage_if #(.W(W_FIRST)) st0 ();
  tgd_stage_if #(.W(W_SECOND)) st1 ();
  tgd_stage_if #(.W(W_UPPER)) st2 ();

  // Two-flop synchronisers for the pins from outside this clock.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      a_s1_r <= 1'b1;
      a_s2_r <= 1'b1;
      b_s1_r <= 1'b1;
      b_s2_r <= 1'b1;
      e_s1_r <= 1'b1;
      e_s2_r <= 1'b1;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
    end else begin
      a_s1_r <= trig_a_n_i;
      a_s2_r <= a_s1_r;
      b_s1_r <= trig_b_n_i;
      b_s2_r <= b_s1_r;
      e_s1_r <= ext_trig_n_i;
      e_s2_r <= e_s1_r;
      done_s1_r <= sample_done_i;
      done_s2_r <= done_s1_r;
    end
  end

  // Source multiplexer; the software strobe is active high, so invert it.
  always_comb begin
    case (trig_sel_i)
      `TGD_SEL_CHA: mux_n = a_s2_r;
      `TGD_SEL_CHB: mux_n = b_s2_r;
      `TGD_SEL_SOFT: mux_n = ~soft_trig_i;
      `TGD_SEL_EXT: mux_n = e_s2_r;
      default: mux_n = 1'b1;
    endcase
  end

  // Threshold code is simply held for the converter.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      level_r <= '0;
    end else begin
      level_r <= trig_level_i;
    end
  end

  // Arming flop: armed while the input is high, fires on the next fall.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      arm_r <= 1'b0;
      mux_prev_r <= 1'b1;
    end else begin
      mux_prev_r <= mux_n;
      arm_r <= mux_n;
    end
  end

  // Stretcher: stays active while low and for the hold time after any edge.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      stretch_cnt_r <= '0;
      stretch_r <= 1'b0;
    end else if (mux_n != mux_prev_r) begin
      stretch_cnt_r <= STRETCH_CYC;
      stretch_r <= stretch_r | (~mux_n & arm_r);
    end else if (stretch_cnt_r != 8'h00) begin
      stretch_cnt_r <= stretch_cnt_r - 8'h01;
    end else if (mux_n) begin
      stretch_r <= 1'b0;
    end
  end

  // The first completed stretch initialises the stretcher after power-up.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      init_r <= 1'b0;
      stretch_prev_r <= 1'b0;
    end else begin
      stretch_prev_r <= stretch_r;
      if (stretch_prev_r && !stretch_r) begin
        init_r <= 1'b1;
      end
    end
  end

  // Only the leading edge of the stretched pulse counts as a start.
  assign start = stretch_r & ~stretch_prev_r & init_r;

  // End-of-sample arrives as a synchronised rising edge.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      done_prev_r <= 1'b0;
    end else begin
      done_prev_r <= done_s2_r;
    end
  end
  assign done_evt = done_s2_r & ~done_prev_r;
  assign latch_set = done_evt | reset_cmd_i;
  // A trigger is taken while the latch stands and is not being set again, even in the IDLE cycle.
  assign accept = start & latch_r & ~latch_set;

  // Reset latch; a set in the same cycle as an accepted trigger wins.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      latch_r <= 1'b0;
    end else if (latch_set) begin
      latch_r <= 1'b1;
    end else if (accept) begin
      latch_r <= 1'b0;
    end
  end

  // Next state of the ramp control sequence.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TGD_ST_IDLE: begin
        if (accept) begin
          state_nxt = TGD_ST_RAMP1;
        end else if (latch_r) begin
          state_nxt = TGD_ST_ARMED;
        end
      end
      TGD_ST_ARMED: begin
        if (accept) begin
          state_nxt = TGD_ST_RAMP1;
        end
      end
      TGD_ST_RAMP1: state_nxt = TGD_ST_COUNT;
      TGD_ST_COUNT: begin
        if (count_out_r) begin
          state_nxt = TGD_ST_RAMP2;
        end
      end
      TGD_ST_RAMP2: begin
        if (done_evt) begin
          state_nxt = TGD_ST_IDLE;
        end
      end
      default: state_nxt = TGD_ST_IDLE;
    endcase
  end

  // State register; the latch setting clears the ramp control at once.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= TGD_ST_IDLE;
    end else if (latch_set) begin
      state_r <= TGD_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ramp runs from trigger to first edge, then from count out to sample.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ramp_on_r <= 1'b0;
      count_en_r <= 1'b0;
    end else begin
      ramp_on_r <= ~latch_set & (state_nxt == TGD_ST_RAMP1 ||
                                 state_nxt == TGD_ST_RAMP2);
      count_en_r <= ~latch_set & (state_nxt == TGD_ST_COUNT);
    end
  end

  // Gated tick to the counter chain.
  assign gate = count_en_r | load_i;
  assign all_full = st0.full & st1.full & st2.full;

  // Load strobe and complemented delay word go to every stage.
  assign st0.load = load_i;
  assign st1.load = load_i;
  assign st2.load = load_i;
  assign st0.d = delay_word_i[W_FIRST-1:0];
  assign st1.d = delay_word_i[W_FIRST+W_SECOND-1:W_FIRST];
  assign st2.d = delay_word_i[W_ALL-1:W_FIRST+W_SECOND];

  // Cascade: fast stage full steps the second, its carry steps the rest.
  assign st0.tick = gate;
  assign st1.tick = gate & (load_i | st0.full);
  assign st2.tick = gate & (load_i | (st0.full & st1.full));

  tgd_stage u_st0 (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .s(st0.stage)
  );
  tgd_stage u_st1 (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .s(st1.stage)
  );
  tgd_stage u_st2 (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .s(st2.stage)
  );

  // Count out is the one tick that follows a full chain.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count_out_r <= 1'b0;
    end else begin
      count_out_r <= count_en_r & ~load_i & all_full;
    end
  end

  // Hold window starts with the accepted trigger.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      hold_cnt_r <= '0;
      hold_sample_r <= 1'b0;
    end else if (accept) begin
      hold_cnt_r <= HOLD_CYC - 12'h001;
      hold_sample_r <= 1'b1;
    end else if (hold_cnt_r != 12'h000) begin
      hold_cnt_r <= hold_cnt_r - 12'h001;
    end else begin
      hold_sample_r <= 1'b0;
    end
  end

  // Clamp release is set by the window start; hold clear by latch or ack.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      clamp_rel_r <= 1'b0;
      hold_clear_r <= 1'b1;
    end else if (accept) begin
      clamp_rel_r <= 1'b1;
      hold_clear_r <= 1'b0;
    end else if (new_data_ack_i || (latch_set && !latch_r)) begin
      clamp_rel_r <= 1'b0;
      hold_clear_r <= 1'b1;
    end
  end

  // Outputs, each from its flop.
  assign trig_level_o = level_r;
  assign stretch_o = stretch_r;
  assign ready_o = latch_r;
  assign ramp_preset_o = latch_r;
  assign comp_latch_o = latch_r;
  assign ramp_on_o = ramp_on_r;
  assign gate_en_o = count_en_r;
  assign count_out_o = count_out_r;
  assign hold_sample_o = hold_sample_r;
  assign hold_clear_o = hold_clear_r;
  assign clamp_release_o = clamp_rel_r;
endmodule // tgd_delay_top

// file: bench/tgd_delay_asserts.sv
// Port assertions of the trigger and coarse-delay block.
`timescale 1ns/1ps
`include "tgd_cfg.svh"
module tgd_delay_asserts #(
  parameter int W_LEVEL = 10
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [W_LEVEL-1:0] trig_level_i,
  input wire logic reset_cmd_i,
  input wire logic new_data_ack_i,
  input wire logic [W_LEVEL-1:0] trig_level_o,
  input wire logic stretch_o,
  input wire logic ready_o,
  input wire logic ramp_preset_o,
  input wire logic comp_latch_o,
  input wire logic ramp_on_o,
  input wire logic gate_en_o,
  input wire logic count_out_o,
  input wire logic hold_sample_o,
  input wire logic hold_clear_o,
  input wire logic clamp_release_o
);
  localparam logic [7:0] HOLD_CYC = 8'(`TGD_HOLD_CYC);
  logic [7:0] hcnt_r;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // Counts the open cycles of the hold sampling window.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !hold_sample_o) begin
      hcnt_r <= 8'h00;
    end else begin
      hcnt_r <= hcnt_r + 8'h01;
    end
  end

  // Each check ties an output to its cause or to the other latch outputs.
  a_level_copy: assert property (
    !$past(reset_i) |-> trig_level_o == $past(trig_level_i))
    else $error("level copy wrong");
  a_latch_set: assert property (reset_cmd_i |=> ready_o)
    else $error("latch not set");
  a_latch_outs: assert property (
    ready_o == ramp_preset_o && comp_latch_o == ready_o)
    else $error("latch outputs disagree");
  a_arm_accept: assert property (
    $rose(stretch_o) && ready_o |=> ramp_on_o && hold_sample_o && !ready_o)
    else $error("armed trigger not taken");
  a_idle_ignore: assert property (
    $rose(stretch_o) && !ready_o |=> !$rose(hold_sample_o))
    else $error("trigger taken while not armed");
  a_stretch_min: assert property ($rose(stretch_o) |-> stretch_o[*8])
    else $error("stretch too short");
  a_gate_open: assert property (
    $rose(gate_en_o) |-> $past(ramp_on_o) && !ramp_on_o)
    else $error("gate opened out of order");
  a_count_gated: assert property (
    count_out_o |-> $past(gate_en_o) && !$past(count_out_o))
    else $error("count output without gate");
  a_hold_len: assert property (
    $fell(hold_sample_o) |-> hcnt_r == HOLD_CYC)
    else $error("hold window length wrong");
  a_hold_clamp: assert property (
    $rose(hold_sample_o) |-> clamp_release_o && !hold_clear_o)
    else $error("clamp not released");
  a_ack_clear: assert property (
    new_data_ack_i |=> $rose(hold_sample_o) ||
                       (hold_clear_o && !clamp_release_o))
    else $error("hold not cleared");

  c_count: cover property ($rose(count_out_o));
  c_rearm: cover property ($rose(ready_o));
  c_hold: cover property ($fell(hold_sample_o));
endmodule // tgd_delay_asserts

bind tgd_delay_top tgd_delay_asserts #(.W_LEVEL(W_LEVEL)) u_tgd_delay_asserts (
  .clk_sys_i, .reset_i, .trig_level_i, .reset_cmd_i, .new_data_ack_i,
  .trig_level_o, .stretch_o, .ready_o, .ramp_preset_o, .comp_latch_o,
  .ramp_on_o, .gate_en_o, .count_out_o, .hold_sample_o, .hold_clear_o,
  .clamp_release_o
);

// file: bench/tgd_host_model.sv
// Processor-side model that drives the block's control port.
`timescale 1ns/1ps
module tgd_host_model (
  input wire logic clk_sys_i,
  output logic [1:0] trig_sel_o,
  output logic [9:0] trig_level_o,
  output logic [23:0] delay_word_o,
  output logic load_o,
  output logic reset_cmd_o,
  output logic ack_o
);
  // Outputs start quiet so no strobe fires during reset.
  initial begin
    trig_sel_o = 2'h0;
    trig_level_o = 10'h000;
    delay_word_o = 24'hFFFFFF;
    load_o = 1'b0;
    reset_cmd_o = 1'b0;
    ack_o = 1'b0;
  end

  // Source select and threshold code are plain levels.
  task automatic select(input logic [1:0] s, input logic [9:0] lvl);
    @(posedge clk_sys_i);
    trig_sel_o <= s;
    trig_level_o <= lvl;
  endtask

  // The delay goes out complemented and is loaded by one strobe cycle.
  task automatic set_delay(input logic [23:0] d);
    @(posedge clk_sys_i);
    delay_word_o <= ~d;
    load_o <= 1'b1;
    @(posedge clk_sys_i);
    load_o <= 1'b0;
  endtask

  // One-cycle strobe: 0 rearms the latch, 1 acknowledges the sample.
  task automatic strobe(input int which);
    @(posedge clk_sys_i);
    if (which == 0) reset_cmd_o <= 1'b1;
    else ack_o <= 1'b1;
    @(posedge clk_sys_i);
    reset_cmd_o <= 1'b0;
    ack_o <= 1'b0;
  endtask
endmodule // tgd_host_model

// file: bench/tgd_delay_top_tb_top.sv
// Self-checking bench for the trigger and coarse-delay block.
`timescale 1ns/1ps
module tgd_delay_top_tb_top;
  logic clk_sys_i, reset_i, done, ld, rcmd, ack;
  logic [3:0] trg_n;
  logic [1:0] sel;
  logic [9:0] lvl, lvl_o;
  logic [23:0] dw;
  logic stretch, ready, ramp_on, gate_en, cnt_out, hold_s, hold_c, clamp_r;
  int n_errors, n_checks, n;

  tgd_host_model u_tgd_host_model (.clk_sys_i, .trig_sel_o(sel),
    .trig_level_o(lvl), .delay_word_o(dw), .load_o(ld),
    .reset_cmd_o(rcmd), .ack_o(ack));

  tgd_delay_top u_tgd_delay_top (.clk_sys_i, .reset_i,
    .trig_a_n_i(trg_n[0]), .trig_b_n_i(trg_n[1]), .ext_trig_n_i(trg_n[3]),
    .soft_trig_i(!trg_n[2]), .trig_sel_i(sel), .trig_level_i(lvl),
    .delay_word_i(dw), .load_i(ld), .reset_cmd_i(rcmd),
    .new_data_ack_i(ack), .sample_done_i(done), .trig_level_o(lvl_o),
    .stretch_o(stretch), .ready_o(ready), .ramp_preset_o(),
    .comp_latch_o(), .ramp_on_o(ramp_on), .gate_en_o(gate_en),
    .count_out_o(cnt_out), .hold_sample_o(hold_s), .hold_clear_o(hold_c),
    .clamp_release_o(clamp_r));

  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [23:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for a level, counting cycles into n, at most 300 of them.
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 300) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n >= 300) chk("wait", 0, 1);
  endtask

  // Holds one trigger source active for len cycles; index 2 is soft.
  task automatic pulse(input int s, input int len);
    @(posedge clk_sys_i);
    trg_n[s] <= 1'b0;
    repeat (len) @(posedge clk_sys_i);
    trg_n[s] <= 1'b1;
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Free-running system clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Cuts a hang short after about 8000 cycles.
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  // Main sequence: init, then one full delayed sample per source.
  initial begin
    reset_i = 1'b1;
    trg_n = 4'hF;
    done = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1;
    chk("hold_clear", 1, hold_c);
    chk("ready", 0, ready);
    u_tgd_host_model.select(2'h2, 10'h000);
    pulse(2, 1);
    pulse(2, 1);
    repeat (12) @(posedge clk_sys_i);
    #1;
    chk("hold idle", 0, hold_s);
    $display("test init done");
    for (int s = 0; s < 4; s++) begin
      u_tgd_host_model.select(s[1:0], 10'h2A5 + 10'(s));
      u_tgd_host_model.set_delay(24'(3 * s + 4));
      u_tgd_host_model.strobe(0);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk("level", 10'h2A5 + 10'(s), lvl_o);
      chk("ready", 1, ready);
      for (int u = 0; u < 4; u++) if (u != s) pulse(u, 3);
      repeat (6) @(posedge clk_sys_i);
      #1;
      chk("unselected", 1, ready);
      pulse(s, 2);
      wait_for(hold_s, 1'b1);
      chk("ready taken", 0, ready);
      wait_for(gate_en, 1'b1);
      wait_for(cnt_out, 1'b1);
      chk("count", 24'(3 * s + 5), 24'(n));
      pulse(s, 2);
      chk("no rearm", 0, ready);
      wait_for(hold_s, 1'b0);
      u_tgd_host_model.strobe(1);
      #1;
      chk("hold_clear", 1, hold_c);
      chk("clamp", 0, clamp_r);
      @(posedge clk_sys_i);
      done <= 1'b1;
      wait_for(ready, 1'b1);
      chk("ramp off", 0, ramp_on);
      chk("hold kept", 1, hold_c);
      @(posedge clk_sys_i);
      done <= 1'b0;
      $display("test source %0d done", s);
    end
    complete_run();
  end
endmodule // tgd_delay_top_tb_top
